// File: shared/filter_vga_config_pkg.sv
package filter_vga_config_pkg;

    // word geometry: printed bit Bn sits at index n-1
    localparam int CFG_WIDTH = 15;
    localparam logic [14:0] CFG_RESET = 15'h0000;
    localparam logic [3:0] CFG_BITS = 4'hF;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [3:0] COUNT_ONE = 4'h1;

    // field positions, as indices into the word
    localparam int CORNER_MSB = 14;
    localparam int CORNER_LSB = 9;
    localparam int POWER_MODE_POS = 8;
    localparam int FIRST_GAIN_MSB = 7;
    localparam int FIRST_GAIN_LSB = 6;
    localparam int SECOND_GAIN_MSB = 5;
    localparam int SECOND_GAIN_LSB = 4;
    localparam int THIRD_GAIN_MSB = 3;
    localparam int THIRD_GAIN_LSB = 2;
    localparam int POST_AMP_POS = 1;
    localparam int OFFSET_DISABLE_POS = 0;

    // corner code that selects bypass
    localparam logic [5:0] CORNER_BYPASS = 6'h00;

    // stage gains in dB
    localparam logic [4:0] GAIN_DB_3 = 5'h03;
    localparam logic [4:0] GAIN_DB_9 = 5'h09;
    localparam logic [4:0] GAIN_DB_12 = 5'h0C;
    localparam logic [4:0] GAIN_DB_15 = 5'h0F;
    localparam logic [4:0] GAIN_DB_18 = 5'h12;
    localparam logic [4:0] GAIN_DB_21 = 5'h15;

    // gain-pair codes
    localparam logic [1:0] PAIR_00 = 2'h0;
    localparam logic [1:0] PAIR_01 = 2'h1;
    localparam logic [1:0] PAIR_10 = 2'h2;
    localparam logic [1:0] PAIR_11 = 2'h3;

endpackage

// File: verilog/rise_detect.sv
`timescale 1ns/1ps
`default_nettype none

module rise_detect
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic level,
    output logic rise
);

    logic prev_ff;
    logic nxt_prev;

    // remember last sample of the level
    always_comb
    begin
        nxt_prev = level;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= nxt_prev;
        end
    end

    // one-cycle pulse on a low-to-high change
    assign rise = level & ~prev_ff;

endmodule

`default_nettype wire

// File: verilog/filter_vga_config_register.sv
`timescale 1ns/1ps
`default_nettype none

module filter_vga_config_register
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_en,
    output logic serial_out,
    output logic [14:0] config_word,
    output logic word_applied,
    output logic word_rejected,
    output logic [5:0] corner_mhz,
    output logic filter_bypass,
    output logic filter_power_high,
    output logic gain_power_high,
    output logic [4:0] first_gain_stage_db,
    output logic [4:0] second_gain_stage_db,
    output logic [4:0] third_gain_stage_db,
    output logic [4:0] post_amp_db,
    output logic offset_correction_enable
);

    logic serial_clk_rise;
    logic latch_rise;

    // shift state
    logic [14:0] shift_ff;
    logic [14:0] nxt_shift;
    logic [3:0] count_ff;
    logic [3:0] nxt_count;
    logic sdo_ff;
    logic nxt_sdo;

    // latched word and its event flags
    logic [14:0] config_ff;
    logic [14:0] nxt_config;
    logic applied_ff;
    logic nxt_applied;
    logic rejected_ff;
    logic nxt_rejected;

    // decoded chain controls
    logic [5:0] corner_ff;
    logic [5:0] nxt_corner;
    logic bypass_ff;
    logic nxt_bypass;
    logic filt_pwr_ff;
    logic nxt_filt_pwr;
    logic gain_pwr_ff;
    logic nxt_gain_pwr;
    logic [4:0] first_db_ff;
    logic [4:0] nxt_first_db;
    logic [4:0] second_db_ff;
    logic [4:0] nxt_second_db;
    logic [4:0] third_db_ff;
    logic [4:0] nxt_third_db;
    logic [4:0] post_db_ff;
    logic [4:0] nxt_post_db;
    logic offset_en_ff;
    logic nxt_offset_en;

    // both pins are already synchronous, so only edges are needed
    rise_detect u_clk_edge
    (
        .clk(clk),
        .rst_b(rst_b),
        .level(serial_clk),
        .rise(serial_clk_rise)
    );

    rise_detect u_latch_edge
    (
        .clk(clk),
        .rst_b(rst_b),
        .level(latch_en),
        .rise(latch_rise)
    );

    // shift msb first while the latch is low; count saturates at a word
    always_comb
    begin
        nxt_shift = shift_ff;
        nxt_count = count_ff;
        nxt_sdo = sdo_ff;
        if (latch_rise)
        begin
            nxt_count = filter_vga_config_pkg::COUNT_ZERO;
        end
        else if (serial_clk_rise && !latch_en)
        begin
            nxt_sdo = shift_ff[14];
            nxt_shift = {shift_ff[13:0], serial_data};
            if (count_ff != filter_vga_config_pkg::CFG_BITS)
            begin
                nxt_count = count_ff + filter_vga_config_pkg::COUNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_ff <= filter_vga_config_pkg::CFG_RESET;
            count_ff <= filter_vga_config_pkg::COUNT_ZERO;
            sdo_ff <= 1'b0;
        end
        else
        begin
            shift_ff <= nxt_shift;
            count_ff <= nxt_count;
            sdo_ff <= nxt_sdo;
        end
    end

    // a short frame is dropped whole so the chain never sees a partial word
    always_comb
    begin
        nxt_config = config_ff;
        nxt_applied = 1'b0;
        nxt_rejected = 1'b0;
        if (latch_rise)
        begin
            if (count_ff == filter_vga_config_pkg::CFG_BITS)
            begin
                nxt_config = shift_ff;
                nxt_applied = 1'b1;
            end
            else
            begin
                nxt_rejected = 1'b1;
            end
        end
    end

    // the latched fifteen-bit store, beside the fifteen-bit shift register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            config_ff <= filter_vga_config_pkg::CFG_RESET;
            applied_ff <= 1'b0;
            rejected_ff <= 1'b0;
        end
        else
        begin
            config_ff <= nxt_config;
            applied_ff <= nxt_applied;
            rejected_ff <= nxt_rejected;
        end
    end

    // map a two-bit code onto the 21/18/15/12 dB ladder
    function automatic logic [4:0] ladder_db(input logic [1:0] code);
        logic [4:0] db;
        db = filter_vga_config_pkg::GAIN_DB_12;
        unique case (code)
            filter_vga_config_pkg::PAIR_00: db = filter_vga_config_pkg::GAIN_DB_21;
            filter_vga_config_pkg::PAIR_01: db = filter_vga_config_pkg::GAIN_DB_18;
            filter_vga_config_pkg::PAIR_10: db = filter_vga_config_pkg::GAIN_DB_15;
            filter_vga_config_pkg::PAIR_11: db = filter_vga_config_pkg::GAIN_DB_12;
        endcase
        return db;
    endfunction

    // decode the latched word; outputs trail the store by one cycle
    always_comb
    begin
        logic power_bit;
        power_bit = config_ff[filter_vga_config_pkg::POWER_MODE_POS];
        nxt_corner = config_ff[filter_vga_config_pkg::CORNER_MSB:
                               filter_vga_config_pkg::CORNER_LSB];
        nxt_bypass = (nxt_corner == filter_vga_config_pkg::CORNER_BYPASS);
        if (nxt_bypass)
        begin
            nxt_gain_pwr = power_bit;
            nxt_filt_pwr = 1'b0;
        end
        else
        begin
            nxt_gain_pwr = 1'b0;
            nxt_filt_pwr = power_bit;
        end
        // fourth code of the first stage repeats 9 dB
        unique case (config_ff[filter_vga_config_pkg::FIRST_GAIN_MSB:
                               filter_vga_config_pkg::FIRST_GAIN_LSB])
            filter_vga_config_pkg::PAIR_00:
                nxt_first_db = filter_vga_config_pkg::GAIN_DB_15;
            filter_vga_config_pkg::PAIR_01:
                nxt_first_db = filter_vga_config_pkg::GAIN_DB_12;
            filter_vga_config_pkg::PAIR_10,
            filter_vga_config_pkg::PAIR_11:
                nxt_first_db = filter_vga_config_pkg::GAIN_DB_9;
        endcase
        nxt_second_db = ladder_db(
            config_ff[filter_vga_config_pkg::SECOND_GAIN_MSB:
                      filter_vga_config_pkg::SECOND_GAIN_LSB]);
        nxt_third_db = ladder_db(
            config_ff[filter_vga_config_pkg::THIRD_GAIN_MSB:
                      filter_vga_config_pkg::THIRD_GAIN_LSB]);
        nxt_post_db = config_ff[filter_vga_config_pkg::POST_AMP_POS] ?
                      filter_vga_config_pkg::GAIN_DB_9 :
                      filter_vga_config_pkg::GAIN_DB_3;
        nxt_offset_en =
            ~config_ff[filter_vga_config_pkg::OFFSET_DISABLE_POS];
    end

    // reset values follow a decode of the all-zero word
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            corner_ff <= filter_vga_config_pkg::CORNER_BYPASS;
            bypass_ff <= 1'b1;
            filt_pwr_ff <= 1'b0;
            gain_pwr_ff <= 1'b0;
            first_db_ff <= filter_vga_config_pkg::GAIN_DB_15;
            second_db_ff <= filter_vga_config_pkg::GAIN_DB_21;
            third_db_ff <= filter_vga_config_pkg::GAIN_DB_21;
            post_db_ff <= filter_vga_config_pkg::GAIN_DB_3;
            offset_en_ff <= 1'b1;
        end
        else
        begin
            corner_ff <= nxt_corner;
            bypass_ff <= nxt_bypass;
            filt_pwr_ff <= nxt_filt_pwr;
            gain_pwr_ff <= nxt_gain_pwr;
            first_db_ff <= nxt_first_db;
            second_db_ff <= nxt_second_db;
            third_db_ff <= nxt_third_db;
            post_db_ff <= nxt_post_db;
            offset_en_ff <= nxt_offset_en;
        end
    end

    // every output straight from a flip-flop
    assign serial_out = sdo_ff;
    assign config_word = config_ff;
    assign word_applied = applied_ff;
    assign word_rejected = rejected_ff;
    assign corner_mhz = corner_ff;
    assign filter_bypass = bypass_ff;
    assign filter_power_high = filt_pwr_ff;
    assign gain_power_high = gain_pwr_ff;
    assign first_gain_stage_db = first_db_ff;
    assign second_gain_stage_db = second_db_ff;
    assign third_gain_stage_db = third_db_ff;
    assign post_amp_db = post_db_ff;
    assign offset_correction_enable = offset_en_ff;

endmodule

`default_nettype wire

// File: testbench/filter_vga_config_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module filter_vga_config_monitor
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic latch_en,
    input wire logic [14:0] config_word,
    input wire logic word_applied,
    input wire logic word_rejected,
    input wire logic [5:0] corner_mhz,
    input wire logic filter_bypass,
    input wire logic filter_power_high,
    input wire logic gain_power_high,
    input wire logic [4:0] first_gain_stage_db,
    input wire logic [4:0] post_amp_db,
    input wire logic offset_correction_enable
);
    // decodes trail the latched word by exactly one cycle
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_corner_field:
    assert property (corner_mhz == $past(config_word[14:9]))
        else $error("corner code off the word");
    a_bypass_mode:
    assert property (filter_bypass == ($past(config_word[14:9]) == 6'h00))
        else $error("bypass flag wrong");
    a_gain_power:
    assert property (gain_power_high == (($past(config_word[14:9]) == 6'h00)
        && $past(config_word[8]))) else $error("gain power wrong");
    a_filter_power:
    assert property (filter_power_high == (($past(config_word[14:9]) != 6'h00)
        && $past(config_word[8]))) else $error("filter power wrong");
    a_first_gain:
    assert property (first_gain_stage_db == (($past(config_word[7:6]) == 2'h0)
        ? 5'h0F : ($past(config_word[7:6]) == 2'h1) ? 5'h0C : 5'h09))
        else $error("first stage gain wrong");
    a_post_amp:
    assert property (post_amp_db == ($past(config_word[1]) ? 5'h09 : 5'h03))
        else $error("post amp gain wrong");
    a_offset_loop:
    assert property (offset_correction_enable == !$past(config_word[0]))
        else $error("offset loop enable wrong");
    // a half-shifted value must never reach the chain
    a_word_hold:
    assert property (!word_applied |-> $stable(config_word))
        else $error("word changed without a latch");
    a_latch_answer:
    assert property ($rose(latch_en) |=> (word_applied ^ word_rejected))
        else $error("latch gave no single answer");
    a_pulse_cause:
    assert property ((word_applied || word_rejected) |->
        ($past(latch_en) && !$past(latch_en, 2)))
        else $error("answer pulse without latch");
endmodule
bind filter_vga_config_register filter_vga_config_monitor mon
(
    .clk, .rst_b, .latch_en, .config_word, .word_applied, .word_rejected,
    .corner_mhz, .filter_bypass, .filter_power_high, .gain_power_high,
    .first_gain_stage_db, .post_amp_db, .offset_correction_enable
);
`default_nettype wire

// File: testbench/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
(
    input wire logic clk,
    output logic serial_clk,
    output logic serial_data,
    output logic latch_en
);
    // pins low at release so no false edge is seen
    initial
    begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_en = 1'b0;
    end
    // msb first; data flips between bits so a stale level is never valid
    task automatic send(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(posedge clk) #2;
            serial_data = v[i];
            serial_clk = 1'b1;
            @(posedge clk) #2;
            serial_clk = 1'b0;
            serial_data = ~serial_data;
        end
        @(posedge clk) #2;
        latch_en = 1'b1;
        @(posedge clk) #2;
    endtask
    // latch stays up one more cycle so decodes settle first
    task automatic release_latch();
        @(posedge clk) #2;
        latch_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: testbench/filter_vga_config_register_tb.sv
`timescale 1ns/1ps
`default_nettype none
module filter_vga_config_register_tb;
    typedef struct {logic [14:0] word; logic [29:0] exp;} row_s;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic serial_clk, serial_data, latch_en, serial_out;
    logic word_applied, word_rejected, filter_bypass;
    logic filter_power_high, gain_power_high, offset_correction_enable;
    logic [14:0] config_word;
    logic [5:0] corner_mhz;
    logic [4:0] g1_db, g2_db, g3_db, post_db;
    int fail_count = 0;
    int checks = 0;
    row_s rows [5];
    wire [29:0] decodes = {corner_mhz, filter_bypass, filter_power_high,
        gain_power_high, g1_db, g2_db, g3_db, post_db,
        offset_correction_enable};
    wire [29:0] pulses = 30'({word_applied, word_rejected});
    always #12.5 clk = ~clk;
    serial_host_model host (.clk(clk), .serial_clk(serial_clk),
        .serial_data(serial_data), .latch_en(latch_en));
    filter_vga_config_register DUT (.clk(clk), .rst_b(rst_b),
        .serial_clk(serial_clk), .serial_data(serial_data),
        .latch_en(latch_en), .serial_out(serial_out),
        .config_word(config_word), .word_applied(word_applied),
        .word_rejected(word_rejected), .corner_mhz(corner_mhz),
        .filter_bypass(filter_bypass), .filter_power_high(filter_power_high),
        .gain_power_high(gain_power_high), .first_gain_stage_db(g1_db),
        .second_gain_stage_db(g2_db), .third_gain_stage_db(g3_db),
        .post_amp_db(post_db),
        .offset_correction_enable(offset_correction_enable));
    task automatic chk(input string n, input logic [29:0] g, e);
        checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog: a hung run counts as a mismatch
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        summarize();
    end
    // rows: word beside corner, bypass/fpwr/gpwr, four gains, loop enable
    initial
    begin
        rows[0] = '{15'h3E00, {6'h1F, 3'h0, 20'h7D6A3, 1'h1}};
        rows[1] = '{15'h7F57, {6'h3F, 3'h2, 20'h64A49, 1'h0}};
        rows[2] = '{15'h01A8, {6'h00, 3'h5, 20'h4BDE3, 1'h1}};
        rows[3] = '{15'h00FF, {6'h00, 3'h4, 20'h4B189, 1'h0}};
        rows[4] = '{15'h0200, {6'h01, 3'h0, 20'h7D6A3, 1'h1}};
        repeat (12) @(posedge clk);
        #2;
        rst_b = 1'b1;
        @(posedge clk) #2;
        chk("reset word", 30'(config_word), 30'h0);
        chk("reset decodes", decodes, {6'h00, 3'h4, 20'h7D6A3, 1'h1});
        foreach (rows[i])
        begin
            host.send(32'(rows[i].word), 15);
            chk("pulses", pulses, 30'h2);
            chk("word", 30'(config_word), 30'(rows[i].word));
            host.release_latch();
            chk("decodes", decodes, rows[i].exp);
        end
        // short frame must leave the applied word untouched
        host.send(32'h0000_3FFF, 14);
        chk("short pulses", pulses, 30'h1);
        host.release_latch();
        chk("short decodes", decodes, rows[4].exp);
        // overlong frame keeps only the last fifteen bits
        host.send(32'h0001_8001, 17);
        chk("long word", 30'(config_word), 30'h1);
        // seventeenth shift pushes out the second bit sent, a one
        chk("long sdo", 30'(serial_out), 30'h1);
        host.release_latch();
        chk("long decodes", decodes, {6'h00, 3'h4, 20'h7D6A3, 1'h0});
        // mid-run reset must bring back the all-zero word and its decode
        @(posedge clk) #2;
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        rst_b = 1'b1;
        @(posedge clk) #2;
        chk("rerun word", 30'(config_word), 30'h0);
        chk("rerun sdo", 30'(serial_out), 30'h0);
        chk("rerun decodes", decodes, {6'h00, 3'h4, 20'h7D6A3, 1'h1});
        summarize();
    end
endmodule
`default_nettype wire
